// file: cpu_model.sv
// Decoder side model raising one pointer op at a time.
// Assumes calls come from a bench sharing ref_clk.
`timescale 1ns/1ps
`default_nettype none
module cpu_model (input wire logic ref_clk, output logic op_inverse, op_load, op_inc, op_move, op_jmp,
   output logic [15:0] op_load_data);
   initial {op_load, op_inc, op_move, op_inverse, op_jmp, op_load_data} = '0;
   // Op held for one edge, then idle so the next edge takes nothing
   task automatic go(input logic [20:0] v);
      @(posedge ref_clk) {op_load, op_inc, op_move, op_inverse, op_jmp, op_load_data} <= v;
      @(posedge ref_clk) {op_load, op_inc, op_move, op_inverse, op_jmp, op_load_data} <= '0;
      #1;
   endtask
endmodule
`default_nettype wire

// file: dual_data_pointer_unit.sv
// Dual 16-bit data pointer unit with its configuration register.
// Assumes the instruction decoder raises at most one pointer operation per cycle
// and that register bus accesses are synchronous to ref_clk.
//
// Functional notes
// - Two 16-bit pointers at 82H/83H and 84H/85H.
// - Select bit chooses pointer for generic operand.
// - Byte registers directly accessible regardless of select.
// - Config bit 2 always reads zero.
// - Inverse prefix flips select for pointer instructions.
// - Indirect jump ignores the inverse prefix.
// - Down bit turns increment into decrement.
// - Direction follows the physically targeted pointer.
// - Down bit sets auto-update direction too.
// - Config at A2H, resets to zero.
// - Update bit post-steps pointer after moves.
`timescale 1ns/1ps
`default_nettype none
module dual_data_pointer_unit (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   input wire logic op_inverse,
   input wire logic op_load,
   input wire logic [15:0] op_load_data,
   input wire logic op_inc,
   input wire logic op_move,
   input wire logic op_jmp,
   output logic [15:0] pointer_addr,
   output logic pointer_select_bit,
   output logic signature_enable
);
   // Stored configuration and pointer bytes
   logic [7:0] config_q;
   logic [7:0] config_d;
   logic [7:0] pointer_zero_low_q;
   logic [7:0] pointer_zero_low_d;
   logic [7:0] pointer_zero_high_q;
   logic [7:0] pointer_zero_high_d;
   logic [7:0] pointer_one_low_q;
   logic [7:0] pointer_one_low_d;
   logic [7:0] pointer_one_high_q;
   logic [7:0] pointer_one_high_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic hit_q;
   logic hit_d;
   logic [15:0] pointer_zero_value;
   logic [15:0] pointer_one_value;

   // Configuration fields
   logic select_bit;
   logic zero_down;
   logic one_down;
   logic zero_update;
   logic one_update;
   logic [7:0] config_view;

   // Register bus decode
   logic wr_zero_low;
   logic wr_zero_high;
   logic wr_one_low;
   logic wr_one_high;
   logic wr_config;
   logic zero_bus_write;
   logic one_bus_write;
   logic [7:0] read_mux;
   logic read_hit;

   // Instruction decode
   logic prefix_active;
   logic target;
   logic zero_targeted;
   logic one_targeted;
   logic zero_load;
   logic one_load;
   logic zero_step;
   logic one_step;
   logic [15:0] zero_stepped;
   logic [15:0] one_stepped;

   // True when a bus write strobe addresses the given register
   function automatic logic write_hits(
      input logic wr,
      input logic [7:0] addr,
      input logic [7:0] reg_addr
   );
      write_hits = wr && (addr == reg_addr);
   endfunction

   // True when an instruction must step the given pointer
   function automatic logic step_wanted(
      input logic targeted,
      input logic load,
      input logic inc,
      input logic move,
      input logic update
   );
      step_wanted = targeted && !load && (inc || (move && update));
   endfunction

   // Byte-wise step, carry or borrow passed from the low to the high byte
   function automatic logic [15:0] step_bytes(
      input logic [15:0] value,
      input logic down
   );
      logic [8:0] low_sum;
      logic [7:0] high_byte;
      low_sum = 9'h000;
      high_byte = 8'h00;
      if (down) begin
         low_sum = {1'b0, value[7:0]} - 9'h001;
         high_byte = value[15:8] - {7'h00, low_sum[8]};
      end else begin
         low_sum = {1'b0, value[7:0]} + 9'h001;
         high_byte = value[15:8] + {7'h00, low_sum[8]};
      end
      step_bytes = {high_byte, low_sum[7:0]};
   endfunction

   // Configuration fields; bit 2 and bit 1 never hold state
   assign select_bit = config_q[pointer_unit_pkg::select_pos];
   assign zero_down = config_q[pointer_unit_pkg::zero_down_pos];
   assign one_down = config_q[pointer_unit_pkg::one_down_pos];
   assign zero_update = config_q[pointer_unit_pkg::zero_update_pos];
   assign one_update = config_q[pointer_unit_pkg::one_update_pos];
   assign config_view = config_q & pointer_unit_pkg::config_store_mask;

   // Bus write strobes, one per register
   assign wr_zero_low = write_hits(sfr_wr, sfr_addr, pointer_unit_pkg::pointer_zero_low_addr);
   assign wr_zero_high = write_hits(sfr_wr, sfr_addr, pointer_unit_pkg::pointer_zero_high_addr);
   assign wr_one_low = write_hits(sfr_wr, sfr_addr, pointer_unit_pkg::pointer_one_low_addr);
   assign wr_one_high = write_hits(sfr_wr, sfr_addr, pointer_unit_pkg::pointer_one_high_addr);
   assign wr_config = write_hits(sfr_wr, sfr_addr, pointer_unit_pkg::pointer_config_addr);
   assign zero_bus_write = wr_zero_low | wr_zero_high;
   assign one_bus_write = wr_one_low | wr_one_high;

   // Prefix flips the choice except for the indirect jump; a bus write to the targeted pointer's bytes drops the op
   assign prefix_active = op_inverse & ~op_jmp;
   assign target = select_bit ^ prefix_active;
   assign zero_targeted = ~target & ~zero_bus_write;
   assign one_targeted = target & ~one_bus_write;
   assign zero_load = zero_targeted & op_load;
   assign one_load = one_targeted & op_load;
   assign zero_step = step_wanted(zero_targeted, op_load, op_inc, op_move, zero_update);
   assign one_step = step_wanted(one_targeted, op_load, op_inc, op_move, one_update);
   assign zero_stepped = step_bytes(pointer_zero_value, zero_down);
   assign one_stepped = step_bytes(pointer_one_value, one_down);

   // Outputs
   assign pointer_zero_value = {pointer_zero_high_q, pointer_zero_low_q};
   assign pointer_one_value = {pointer_one_high_q, pointer_one_low_q};
   assign pointer_addr = target ? pointer_one_value : pointer_zero_value;
   assign pointer_select_bit = select_bit;
   assign signature_enable = config_q[pointer_unit_pkg::sigen_pos];
   assign sfr_rdata = rdata_q;
   assign sfr_hit = hit_q;

   // Configuration next value; a bus write keeps only the stored bits
   always_comb begin
      config_d = config_q;
      if (wr_config) begin
         config_d = sfr_wdata & pointer_unit_pkg::config_store_mask;
      end
   end

   // Pointer zero low byte
   always_comb begin
      pointer_zero_low_d = pointer_zero_low_q;
      if (wr_zero_low) begin
         pointer_zero_low_d = sfr_wdata;
      end else if (zero_load) begin
         pointer_zero_low_d = op_load_data[7:0];
      end else if (zero_step) begin
         pointer_zero_low_d = zero_stepped[7:0];
      end
   end

   // Pointer zero high byte
   always_comb begin
      pointer_zero_high_d = pointer_zero_high_q;
      if (wr_zero_high) begin
         pointer_zero_high_d = sfr_wdata;
      end else if (zero_load) begin
         pointer_zero_high_d = op_load_data[15:8];
      end else if (zero_step) begin
         pointer_zero_high_d = zero_stepped[15:8];
      end
   end

   // Pointer one low byte
   always_comb begin
      pointer_one_low_d = pointer_one_low_q;
      if (wr_one_low) begin
         pointer_one_low_d = sfr_wdata;
      end else if (one_load) begin
         pointer_one_low_d = op_load_data[7:0];
      end else if (one_step) begin
         pointer_one_low_d = one_stepped[7:0];
      end
   end

   // Pointer one high byte
   always_comb begin
      pointer_one_high_d = pointer_one_high_q;
      if (wr_one_high) begin
         pointer_one_high_d = sfr_wdata;
      end else if (one_load) begin
         pointer_one_high_d = op_load_data[15:8];
      end else if (one_step) begin
         pointer_one_high_d = one_stepped[15:8];
      end
   end

   // Read decode
   always_comb begin
      read_hit = 1'b1;
      unique case (sfr_addr)
         pointer_unit_pkg::pointer_zero_low_addr: read_mux = pointer_zero_low_q;
         pointer_unit_pkg::pointer_zero_high_addr: read_mux = pointer_zero_high_q;
         pointer_unit_pkg::pointer_one_low_addr: read_mux = pointer_one_low_q;
         pointer_unit_pkg::pointer_one_high_addr: read_mux = pointer_one_high_q;
         pointer_unit_pkg::pointer_config_addr: read_mux = config_view;
         default: begin
            read_mux = pointer_unit_pkg::read_reset;
            read_hit = 1'b0;
         end
      endcase
   end

   // Read data held until the next read strobe
   always_comb begin
      rdata_d = rdata_q;
      if (sfr_rd) begin
         rdata_d = read_mux;
      end
   end
   assign hit_d = sfr_rd & read_hit;

   // Configuration register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         config_q <= pointer_unit_pkg::config_reset;
      end else begin
         config_q <= config_d;
      end
   end

   // Pointer zero low register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pointer_zero_low_q <= pointer_unit_pkg::pointer_reset[7:0];
      end else begin
         pointer_zero_low_q <= pointer_zero_low_d;
      end
   end

   // Pointer zero high register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pointer_zero_high_q <= pointer_unit_pkg::pointer_reset[15:8];
      end else begin
         pointer_zero_high_q <= pointer_zero_high_d;
      end
   end

   // Pointer one low register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pointer_one_low_q <= pointer_unit_pkg::pointer_reset[7:0];
      end else begin
         pointer_one_low_q <= pointer_one_low_d;
      end
   end

   // Pointer one high register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pointer_one_high_q <= pointer_unit_pkg::pointer_reset[15:8];
      end else begin
         pointer_one_high_q <= pointer_one_high_d;
      end
   end

   // Read data register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= pointer_unit_pkg::read_reset;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Hit flag, one cycle after a read of a mapped address
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hit_q <= 1'b0;
      end else begin
         hit_q <= hit_d;
      end
   end
endmodule
`default_nettype wire

// file: dual_data_pointer_unit_properties.sv
// Port checker of the dual data pointer unit.
// Assumes the one-cycle register bus and op contract.
`timescale 1ns/1ps
`default_nettype none
module pointer_checker (input wire logic ref_clk, rst_n, sfr_wr, sfr_rd, sfr_hit, op_inverse, op_load, op_inc,
   op_move, op_jmp, pointer_select_bit, input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata,
   input wire logic [15:0] op_load_data, pointer_addr);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire logic cfg = sfr_addr == pointer_unit_pkg::pointer_config_addr;
   wire logic q = !op_jmp && !sfr_wr;
   wire logic mapped = sfr_addr inside {[8'h82:8'h85], 8'ha2};
   sequence k; !op_jmp && $stable(op_inverse); endsequence
   property p_hit; sfr_rd |=> sfr_hit == $past(mapped); endproperty
   a_hit: assert property (p_hit) else $error("bad hit");
   property p_cfg; sfr_rd && cfg && !sfr_wr |=> sfr_rdata[2:0] == {2'b00, pointer_select_bit}; endproperty
   a_cfg: assert property (p_cfg) else $error("bad config read");
   property p_sel; sfr_wr && cfg |=> pointer_select_bit == $past(sfr_wdata[0]); endproperty
   a_sel: assert property (p_sel) else $error("bad select");
   property p_rdh; !sfr_rd |=> $stable(sfr_rdata); endproperty
   a_rdh: assert property (p_rdh) else $error("read data moved");
   property p_hold; !(op_load || op_inc || op_move) && q ##1 k |-> $stable(pointer_addr); endproperty
   a_hold: assert property (p_hold) else $error("pointer moved");
   property p_load; op_load && q ##1 k |-> pointer_addr == $past(op_load_data); endproperty
   a_load: assert property (p_load) else $error("bad load");
   property p_inc; op_inc && !op_load && q ##1 k |-> pointer_addr - $past(pointer_addr) inside {16'h0001, 16'hffff};
   endproperty
   a_inc: assert property (p_inc) else $error("bad step");
   property p_mov; op_move && !op_load && !op_inc && q ##1 k |-> pointer_addr - $past(pointer_addr) + 16'h0001 <= 16'h0002;
   endproperty
   a_mov: assert property (p_mov) else $error("bad move step");
   c_inv: cover property (op_inc && op_inverse);
   c_jmp: cover property (op_jmp && op_inverse);
   c_miss: cover property (sfr_rd && !cfg ##1 !sfr_hit);
endmodule
bind dual_data_pointer_unit pointer_checker checks (.*);
`default_nettype wire

// file: dual_data_pointer_unit_test.sv
// Bench of the pointer unit: bus and op sequences with checks.
// Assumes package, design, checker and decoder model come first.
`timescale 1ns/1ps
`default_nettype none
module dual_data_pointer_unit_test;
   logic ref_clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, sfr_hit, op_inverse, op_load, op_inc, op_move, op_jmp;
   logic pointer_select_bit, signature_enable;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
   logic [15:0] op_load_data, pointer_addr;
   logic [7:0] ra [6] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'ha2, 8'h86};
   logic [7:0] wd [4] = '{8'hff, 8'h12, 8'hff, 8'hff};
   int n_errors = 0, comparisons = 0;
   always #2 ref_clk = ~ref_clk;
   dual_data_pointer_unit dut (.*);
   cpu_model cpu (.*);
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic h);
      @(posedge ref_clk) {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} <= {w, !w, a, d};
      @(posedge ref_clk) {sfr_wr, sfr_rd} <= 2'b00;
      #1 if (!w) chk({sfr_hit, sfr_rdata}, {h, d});
   endtask
   task automatic wrap_up;
      $display("mismatches %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #2000 n_errors++;
      wrap_up();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1;
      foreach (ra[i]) acc(0, ra[i], 8'h00, i < 5);
      for (int i = 0; i < 4; i++) acc(1, ra[i], wd[i], 0);
      acc(0, 8'h83, 8'h12, 1);
      $display("register tests done");
      cpu.go({5'b01000, 16'h0000});
      chk(pointer_addr, 16'h1300);
      cpu.go({5'b01010, 16'h0000});
      acc(0, 8'h84, 8'h00, 1);
      acc(1, 8'ha2, 8'h11, 0);
      acc(0, 8'ha2, 8'h11, 1);
      cpu.go({5'b01010, 16'h0000});
      acc(0, 8'h82, 8'hff, 1);
      acc(1, 8'ha2, 8'hff, 0);
      acc(0, 8'ha2, 8'hf9, 1);
      chk(signature_enable, 1'b1);
      chk(pointer_select_bit, 1'b1);
      cpu.go({5'b00100, 16'h0000});
      chk(pointer_addr, 16'hffff);
      fork
         cpu.go({5'b00011, 16'h0000});
         #5 chk(pointer_addr, 16'hffff);
      join
      acc(1, 8'ha2, 8'h01, 0);
      chk(signature_enable, 1'b0);
      cpu.go({5'b00100, 16'h0000});
      chk(pointer_addr, 16'hffff);
      cpu.go({5'b10000, 16'hbeef});
      acc(0, 8'h85, 8'hbe, 1);
      @(posedge ref_clk) rst_n <= 0;
      @(posedge ref_clk) rst_n <= 1;
      #1 chk(pointer_addr, 16'h0000);
      acc(0, 8'ha2, 8'h00, 1);
      acc(0, 8'h85, 8'h00, 1);
      $display("op tests done");
      wrap_up();
   end
endmodule
`default_nettype wire

// file: pointer_unit_pkg.sv
// Constants shared by the dual data pointer unit.
// Assumes a byte-wide special-function register bus with 8-bit addresses.
package pointer_unit_pkg;
   // Register addresses on the special-function register bus
   localparam logic [7:0] pointer_zero_low_addr = 8'h82;
   localparam logic [7:0] pointer_zero_high_addr = 8'h83;
   localparam logic [7:0] pointer_one_low_addr = 8'h84;
   localparam logic [7:0] pointer_one_high_addr = 8'h85;
   localparam logic [7:0] pointer_config_addr = 8'ha2;

   // Field positions in the pointer configuration register
   localparam int select_pos = 0;
   localparam int unused_pos = 1;
   localparam int zero_pos = 2;
   localparam int sigen_pos = 3;
   localparam int zero_down_pos = 4;
   localparam int one_down_pos = 5;
   localparam int zero_update_pos = 6;
   localparam int one_update_pos = 7;

   // Bits that hold state; bit 2 is wired low and bit 1 is not implemented
   localparam logic [7:0] config_store_mask = 8'hf9;

   // Values after reset
   localparam logic [7:0] config_reset = 8'h00;
   localparam logic [15:0] pointer_reset = 16'h0000;
   localparam logic [7:0] read_reset = 8'h00;

   // One step of a pointer, up or down, wrapping across all 16 bits
   function automatic logic [15:0] step_pointer(input logic [15:0] value, input logic down);
      step_pointer = down ? value - 16'h0001 : value + 16'h0001;
   endfunction
endpackage
